// File: hw/interval_timer_defs.svh
`ifndef INTERVAL_TIMER_DEFS_SVH
`define INTERVAL_TIMER_DEFS_SVH

// register byte offsets on the apb slave
`define PERIPH_EN_OFF     8'h00
`define PRESCALER_OFF     8'h04
`define TRIG_MODE_OFF     8'h08
`define WAIT_MODE_OFF     8'h0C
`define TRIG_PERIOD_OFF   8'h10
`define WAIT_PERIOD_OFF   8'h14
`define TRIG_COUNT_OFF    8'h18
`define WAIT_COUNT_OFF    8'h1C
`define START_OFF         8'h20
`define STOP_OFF          8'h24
`define RUN_STATUS_OFF    8'h28
`define IRQ_STATUS_OFF    8'h2C
`define IRQ_MASK_OFF      8'h30

// mode register field positions
`define MODE_MD_LSB       0
`define MODE_MD_MSB       3
`define MODE_STS_LSB      8
`define MODE_STS_MSB      10
`define MODE_SPLIT_BIT    11
`define MODE_CCS_BIT      12
`define MODE_MASTER_BIT   13
`define MODE_CKS_LSB      14
`define MODE_CKS_MSB      15

// prescaler register fields: clock a in [3:0], clock b in [7:4]
`define PRS_A_LSB         0
`define PRS_B_LSB         4

// reset values
`define MODE_RST          16'h0000
`define PRESCALER_RST     8'h00
`define TRIG_PERIOD_RST   16'h7CFF
`define WAIT_PERIOD_RST   16'h001F

// timing: 1 ms trigger at the undivided count clock
`define SYS_CLK_HZ        32000000
`define TRIG_INTERVAL_US  1000

`endif

// File: hw/interval_timer_pkg.sv
package interval_timer_pkg;
   typedef enum logic {
      CH_IDLE,
      CH_COUNTING
   } chan_state_e;
   typedef logic [15:0] count_t;
   typedef logic [7:0]  reg_addr_t;
endpackage

// File: hw/clock_prescaler.sv
`timescale 1ns/100ps
// two prescaled count enables, each clk divided by 2^n
module clock_prescaler (
   input  wire logic       clk,
   input  wire logic       reset_n,
   input  wire logic       run,
   input  wire logic [3:0] div_a,
   input  wire logic [3:0] div_b,
   output logic            tick_a,
   output logic            tick_b
);
   logic [15:0] free_cnt;
   logic [15:0] mask_a;
   logic [15:0] mask_b;

   // a zero selector gives all-zero mask, so the tick is every cycle
   assign mask_a = 16'((17'h00001 << div_a) - 17'h00001);
   assign mask_b = 16'((17'h00001 << div_b) - 17'h00001);
   assign tick_a = run && ((free_cnt & mask_a) == mask_a); // R4
   assign tick_b = run && ((free_cnt & mask_b) == mask_b);

   // held at zero while the unit has no clock supply
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n)
         free_cnt <= 16'h0000;
      else if (!run)
         free_cnt <= 16'h0000; // R1
      else
         free_cnt <= free_cnt + 16'h0001;
   end
endmodule

// File: hw/timer_channel.sv
`timescale 1ns/100ps
// one interval-timer channel: down counter with reload
module timer_channel (
   input  wire logic                          clk,
   input  wire logic                          reset_n,
   input  wire logic                          tick,
   input  wire logic                          start,
   input  wire logic                          stop,
   input  wire interval_timer_pkg::count_t    period,
   input  wire logic                          split,
   input  wire logic                          start_irq,
   output logic                               running,
   output interval_timer_pkg::count_t         count,
   output logic                               period_irq
);
   import interval_timer_pkg::*;

   chan_state_e state;
   count_t      reload;
   logic        at_end;

   // split mode uses only the low byte; otherwise a full 16-bit count
   assign reload  = split ? {8'h00, period[7:0]} : period; // R8
   assign at_end  = (count == 16'h0000);
   assign running = (state == CH_COUNTING);

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         state      <= CH_IDLE;
         count      <= 16'h0000;
         period_irq <= 1'b0;
      end else begin
         period_irq <= 1'b0;
         unique case (state)
            CH_IDLE: begin
               if (start) begin
                  state      <= CH_COUNTING;
                  count      <= reload;
                  period_irq <= start_irq; // R2 R3
               end
            end
            CH_COUNTING: begin
               if (stop) begin
                  state <= CH_IDLE;
               end else if (start) begin
                  count <= reload; // restart reloads at once
               end else if (tick && at_end) begin
                  count      <= reload; // R14 R10
                  period_irq <= 1'b1; // R14
               end else if (tick) begin
                  count <= count - 16'h0001;
               end
            end
         endcase
      end
   end
endmodule

// File: hw/interval_timer_channels.sv
// Design decisions made here: the address map and the APB slave port.
`timescale 1ns/100ps
`include "interval_timer_defs.svh"

// Function
// R1 - no clock or register access until enabled
// R2 - trigger mode zero: interval, no start interrupt
// R3 - wait mode zero: interval, no start interrupt
// R4 - prescaler zero runs at system clock
// R5 - clock select zero picks prescaled clock a
// R6 - count source zero counts operating clock
// R7 - master zero means independent channel
// R8 - split zero means one 16-bit counter
// R9 - start source zero: software start only
// R10 - period is data value plus one ticks
// R11 - trigger channel interrupt starts the converter
// R12 - software loads 7CFF for 1 ms wait
// R13 - software loads 1F for 1 us wait
// R14 - reload at end, pulse interrupt, keep counting
module interval_timer_channels (
   input  wire logic                          clk,
   input  wire logic                          reset_n,
   input  wire logic                          psel,
   input  wire logic                          penable,
   input  wire logic                          pwrite,
   input  wire interval_timer_pkg::reg_addr_t paddr,
   input  wire logic [31:0]                   pwdata,
   output logic [31:0]                        prdata,
   output logic                               pready,
   output logic                               pslverr,
   output logic                               trigger_period_irq,
   output logic                               wait_period_irq,
   output logic                               irq
);
   import interval_timer_pkg::*;

   localparam int NCH = 2;
   localparam int TRIG = 0;
   localparam int WAIT = 1;

   // software-visible state
   logic           timer_unit_clock_enable;
   logic [7:0]     prescaler_select_reg;
   logic [15:0]    mode_reg [NCH];
   count_t         period_reg [NCH];
   logic [NCH-1:0] irq_status;
   logic [NCH-1:0] irq_mask;

   // per-channel wiring
   logic [NCH-1:0] ch_tick;
   logic [NCH-1:0] ch_start;
   logic [NCH-1:0] ch_stop;
   logic [NCH-1:0] ch_running;
   logic [NCH-1:0] ch_event;
   count_t         ch_count [NCH];

   logic           prescaled_clock_a;
   logic           prescaled_clock_b;

   // bus decode
   logic           setup_phase;
   logic           access_phase;
   logic           wr_stb;
   logic           rd_setup;
   logic           hit_en;
   logic           hit_prs;
   logic           hit_tmode;
   logic           hit_wmode;
   logic           hit_tper;
   logic           hit_wper;
   logic           hit_tcnt;
   logic           hit_wcnt;
   logic           hit_start;
   logic           hit_stop;
   logic           hit_run;
   logic           hit_ists;
   logic           hit_imask;
   logic           mapped;
   logic           unit_open;
   logic [31:0]    next_prdata;

   assign setup_phase  = psel && !penable;
   assign access_phase = psel && penable;
   assign pready       = 1'b1;

   assign hit_en    = (paddr == `PERIPH_EN_OFF);
   assign hit_prs   = (paddr == `PRESCALER_OFF);
   assign hit_tmode = (paddr == `TRIG_MODE_OFF);
   assign hit_wmode = (paddr == `WAIT_MODE_OFF);
   assign hit_tper  = (paddr == `TRIG_PERIOD_OFF);
   assign hit_wper  = (paddr == `WAIT_PERIOD_OFF);
   assign hit_tcnt  = (paddr == `TRIG_COUNT_OFF);
   assign hit_wcnt  = (paddr == `WAIT_COUNT_OFF);
   assign hit_start = (paddr == `START_OFF);
   assign hit_stop  = (paddr == `STOP_OFF);
   assign hit_run   = (paddr == `RUN_STATUS_OFF);
   assign hit_ists  = (paddr == `IRQ_STATUS_OFF);
   assign hit_imask = (paddr == `IRQ_MASK_OFF);

   assign mapped = hit_en | hit_prs | hit_tmode | hit_wmode | hit_tper
                 | hit_wper | hit_tcnt | hit_wcnt | hit_start | hit_stop
                 | hit_run | hit_ists | hit_imask;

   // the enable register itself must stay reachable, the rest is locked
   assign unit_open = timer_unit_clock_enable; // R1
   assign pslverr   = access_phase && !mapped;
   assign wr_stb    = access_phase && pwrite && mapped && pready;
   assign rd_setup  = setup_phase && !pwrite;

   // read mux: locked registers read as zero while the unit is off
   always_comb begin
      next_prdata = 32'h0000_0000;
      if (hit_en)
         next_prdata = {31'h0000_0000, timer_unit_clock_enable};
      else if (unit_open) begin // R1
         if (hit_prs)
            next_prdata = {24'h00_0000, prescaler_select_reg};
         else if (hit_tmode)
            next_prdata = {16'h0000, mode_reg[TRIG]};
         else if (hit_wmode)
            next_prdata = {16'h0000, mode_reg[WAIT]};
         else if (hit_tper)
            next_prdata = {16'h0000, period_reg[TRIG]};
         else if (hit_wper)
            next_prdata = {16'h0000, period_reg[WAIT]};
         else if (hit_tcnt)
            next_prdata = {16'h0000, ch_count[TRIG]};
         else if (hit_wcnt)
            next_prdata = {16'h0000, ch_count[WAIT]};
         else if (hit_run)
            next_prdata = {30'h0000_0000, ch_running};
         else if (hit_ists)
            next_prdata = {30'h0000_0000, irq_status};
         else if (hit_imask)
            next_prdata = {30'h0000_0000, irq_mask};
      end
   end

   // read data is captured in the setup cycle so it is a flop output
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n)
         prdata <= 32'h0000_0000;
      else if (rd_setup)
         prdata <= next_prdata;
   end

   // clock-supply enable, always writable
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n)
         timer_unit_clock_enable <= 1'b0;
      else if (wr_stb && hit_en)
         timer_unit_clock_enable <= pwdata[0]; // R1
   end

   // prescaler select; locked while the unit has no clock
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n)
         prescaler_select_reg <= `PRESCALER_RST;
      else if (wr_stb && hit_prs && unit_open)
         prescaler_select_reg <= pwdata[7:0]; // R1
   end

   // mode and period registers of both channels
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         mode_reg[TRIG]   <= `MODE_RST;
         mode_reg[WAIT]   <= `MODE_RST;
         period_reg[TRIG] <= `TRIG_PERIOD_RST;
         period_reg[WAIT] <= `WAIT_PERIOD_RST;
      end else if (wr_stb && unit_open) begin
         if (hit_tmode)
            mode_reg[TRIG] <= pwdata[15:0];
         if (hit_wmode)
            mode_reg[WAIT] <= pwdata[15:0];
         if (hit_tper)
            period_reg[TRIG] <= pwdata[15:0]; // R10
         if (hit_wper)
            period_reg[WAIT] <= pwdata[15:0]; // R12 R13
      end
   end

   // interrupt mask
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n)
         irq_mask <= 2'b00;
      else if (wr_stb && hit_imask && unit_open)
         irq_mask <= pwdata[NCH-1:0];
   end

   // sticky status, write one to clear; a new event beats the clear
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n)
         irq_status <= 2'b00;
      else if (wr_stb && hit_ists && unit_open)
         irq_status <= (irq_status & ~pwdata[NCH-1:0]) | ch_event;
      else
         irq_status <= irq_status | ch_event;
   end

   assign irq = |(irq_status & irq_mask);

   // prescaled count enables, stopped while the unit is unclocked
   clock_prescaler u_prescaler (
      .clk     (clk),
      .reset_n (reset_n),
      .run     (timer_unit_clock_enable),
      .div_a   (prescaler_select_reg[`PRS_A_LSB +: 4]),
      .div_b   (prescaler_select_reg[`PRS_B_LSB +: 4]),
      .tick_a  (prescaled_clock_a),
      .tick_b  (prescaled_clock_b)
   );

   genvar g;
   generate
      for (g = 0; g < NCH; g++) begin : g_ch
         logic [1:0] clock_sel;
         logic [2:0] start_src;
         logic [3:0] op_mode;
         logic       channel_operating_clock;
         logic       channel_count_clock;
         logic       soft_start;

         assign clock_sel = mode_reg[g][`MODE_CKS_MSB:`MODE_CKS_LSB];
         assign start_src = mode_reg[g][`MODE_STS_MSB:`MODE_STS_LSB];
         assign op_mode   = mode_reg[g][`MODE_MD_MSB:`MODE_MD_LSB];

         // only code zero picks clock a; other codes fall to clock b
         assign channel_operating_clock = (clock_sel == 2'b00)
                                        ? prescaled_clock_a // R5
                                        : prescaled_clock_b;

         // no other count source exists, so a set selector halts it
         assign channel_count_clock = channel_operating_clock
                                    && !mode_reg[g][`MODE_CCS_BIT]; // R6

         assign ch_tick[g] = channel_count_clock && timer_unit_clock_enable;

         // start bit written by software; hardware sources not wired
         assign soft_start  = wr_stb && hit_start && unit_open
                            && pwdata[g];
         assign ch_start[g] = soft_start && (start_src == 3'b000); // R9
         // stop wins when the unit loses its clock
         assign ch_stop[g]  = (wr_stb && hit_stop && unit_open && pwdata[g])
                            || !timer_unit_clock_enable; // R1

         // each channel is started only by its own trigger, never slaved
         timer_channel u_channel ( // R7
            .clk        (clk),
            .reset_n    (reset_n),
            .tick       (ch_tick[g]),
            .start      (ch_start[g]),
            .stop       (ch_stop[g]),
            .period     (period_reg[g]),
            .split      (mode_reg[g][`MODE_SPLIT_BIT]), // R8
            .start_irq  (op_mode[0]), // R2 R3
            .running    (ch_running[g]),
            .count      (ch_count[g]),
            .period_irq (ch_event[g])
         );
      end
   endgenerate

   // one-cycle pulses out; the trigger one feeds the converter start
   assign trigger_period_irq = ch_event[TRIG]; // R11
   assign wait_period_irq    = ch_event[WAIT];
endmodule

// File: tb/interval_timer_channels_props.sv
`timescale 1ns/100ps
`include "interval_timer_defs.svh"
// port-side checks of the two timer channels
module interval_timer_channels_props (
   input wire logic                          clk,
   input wire logic                          reset_n,
   input wire logic                          psel,
   input wire logic                          penable,
   input wire logic                          pwrite,
   input wire interval_timer_pkg::reg_addr_t paddr,
   input wire logic [31:0]                   pwdata,
   input wire logic [31:0]                   prdata,
   input wire logic                          pready,
   input wire logic                          pslverr,
   input wire logic                          trigger_period_irq,
   input wire logic                          wait_period_irq,
   input wire logic                          irq
);
   import interval_timer_pkg::*;
   default clocking @(posedge clk); endclocking
   default disable iff (!reset_n);
   logic        en_q;
   logic        en_old;
   logic [1:0]  seen;
   count_t      per [2];
   logic [16:0] gap [2];
   logic [15:0] mode [2];
   logic [3:0]  prs;
   // decoded bus events
   wire         wr = psel && penable && pwrite && pready;
   wire         rd = psel && penable && !pwrite;
   wire [1:0]   hit = {wait_period_irq, trigger_period_irq};
   wire         ctl_wr = wr && (paddr == `IRQ_MASK_OFF ||
                                paddr == `PERIPH_EN_OFF);
   wire         clr_wr = wr && paddr == `IRQ_STATUS_OFF;
   wire         irq_up = ctl_wr || (|hit);
   wire         irq_dn = ctl_wr || clr_wr;
   wire         drop = wr && !clr_wr && paddr != `IRQ_MASK_OFF;
   // mirror of the programming; a reconfiguring write suspends the
   // spacing check until the next clean software start
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         en_q   <= 1'h0;
         en_old <= 1'h0;
         prs    <= 4'h0;
         seen   <= 2'h0;
         per    <= '{16'h7CFF, 16'h001F};
         mode   <= '{16'h0000, 16'h0000};
         gap    <= '{17'h00000, 17'h00000};
      end else begin
         en_old <= en_q;
         if (wr && paddr == `PERIPH_EN_OFF)
            en_q <= pwdata[0];
         if (wr && en_q && paddr == `PRESCALER_OFF)
            prs <= pwdata[3:0];
         for (int c = 0; c < 2; c++) begin
            gap[c] <= hit[c] ? 17'h00001 : gap[c] + 17'h00001;
            if (wr && en_q && paddr == `TRIG_PERIOD_OFF + 8'(4 * c))
               per[c] <= pwdata[15:0];
            if (wr && en_q && paddr == `TRIG_MODE_OFF + 8'(4 * c))
               mode[c] <= pwdata[15:0];
            if (wr && paddr == `START_OFF && pwdata[c]) begin
               seen[c] <= en_q && mode[c] == 16'h0 && prs == 4'h0;
               gap[c]  <= 17'h00000;
            end else if (drop) begin
               seen[c] <= 1'h0;
            end
         end
      end
   end
   trig_gap_exact_a: assert property (
      seen[0] && trigger_period_irq |-> gap[0] == {1'h0, per[0]} + 17'h1)
      else $error("trigger pulse spacing wrong");
   trig_gap_bound_a: assert property (
      seen[0] |-> gap[0] <= {1'h0, per[0]} + 17'h1)
      else $error("trigger pulse missing");
   wait_gap_exact_a: assert property (
      seen[1] && wait_period_irq |-> gap[1] == {1'h0, per[1]} + 17'h1)
      else $error("wait pulse spacing wrong");
   wait_gap_bound_a: assert property (
      seen[1] |-> gap[1] <= {1'h0, per[1]} + 17'h1)
      else $error("wait pulse missing");
   off_no_pulse_a: assert property (
      !en_q && !en_old |-> hit == 2'h0)
      else $error("pulse while unit disabled");
   off_read_zero_a: assert property (
      rd && !en_q |-> prdata == 32'h0)
      else $error("register readable while disabled");
   irq_rise_a: assert property (
      $rose(irq) |-> $past(irq_up))
      else $error("interrupt rose without cause");
   irq_fall_a: assert property (
      $fell(irq) |-> $past(irq_dn))
      else $error("interrupt fell without clear");
   pulse_single_a: assert property (
      trigger_period_irq && per[0] != 16'h0 |=> !trigger_period_irq)
      else $error("trigger pulse longer than a cycle");
   trig_seen_c: cover property (seen[0] && trigger_period_irq);
   wait_seen_c: cover property (seen[1] && wait_period_irq);
   irq_rise_c: cover property ($rose(irq));
endmodule
bind interval_timer_channels interval_timer_channels_props u_props (
   .clk(clk), .reset_n(reset_n), .psel(psel), .penable(penable),
   .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
   .pready(pready), .pslverr(pslverr), .irq(irq),
   .trigger_period_irq(trigger_period_irq),
   .wait_period_irq(wait_period_irq));

// File: tb/adc_trigger_model.sv
`timescale 1ns/100ps
// converter trigger input: each trigger pulse launches one conversion
module adc_trigger_model (
   input  wire logic   clk,
   input  wire logic   reset_n,
   input  wire logic   hw_trigger,
   output logic [15:0] conv_count
);
   // the trigger lasts one cycle, so it is counted on the edge that sees it
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         conv_count <= 16'h0000;
      end else if (hw_trigger) begin
         conv_count <= conv_count + 16'h0001;
      end
   end
endmodule

// File: tb/tb_interval_timer_channels.sv
`timescale 1ns/100ps
`include "interval_timer_defs.svh"
`define CHK(nm, ex, got) begin \
   tests_run++; \
   if ((got) !== (ex)) begin \
      fail_count++; \
      $display("Error %s expected %h seen %h", nm, ex, got); \
   end \
end
module tb_interval_timer_channels;
   import interval_timer_pkg::*;
   typedef struct packed {
      logic        w;
      reg_addr_t   a;
      logic [31:0] d;
      logic [31:0] ex;
      logic        err;
   } row_s;
   logic        clk;
   logic        reset_n;
   logic        psel;
   logic        penable;
   logic        pwrite;
   reg_addr_t   paddr;
   logic [31:0] pwdata;
   logic [31:0] prdata;
   logic        pready;
   logic        pslverr;
   logic        trigger_period_irq;
   logic        wait_period_irq;
   logic        irq;
   logic [15:0] conv_count;
   logic [31:0] rd;
   logic        er;
   row_s        rows [11];
   int          fail_count = 0;
   int          tests_run = 0;
   int          cycles = 0;
   int          n;
   interval_timer_channels u_interval_timer_channels (
      .clk(clk), .reset_n(reset_n), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .irq(irq),
      .trigger_period_irq(trigger_period_irq),
      .wait_period_irq(wait_period_irq));
   adc_trigger_model u_adc_trigger_model (
      .clk(clk), .reset_n(reset_n), .hw_trigger(trigger_period_irq),
      .conv_count(conv_count));
   // free-running 25 MHz clock
   initial begin
      clk = 1'h0;
      forever #20 clk = ~clk;
   end
   // the long trigger test needs about 65k cycles, so cut hangs at 90k
   always @(posedge clk) begin
      cycles++;
      if (cycles == 90000) begin
         fail_count++;
         report_and_stop();
      end
   end
   task report_and_stop();
      $display("checks %0d mismatches %0d", tests_run, fail_count);
      if (fail_count == 0 && tests_run > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask
   // one apb transfer; request held until pready is sampled high or 16 access cycles pass
   task automatic apb(input logic w, input reg_addr_t a,
                      input logic [31:0] d, output logic [31:0] r,
                      output logic e);
      int k;
      k = 0;
      @(posedge clk);
      psel    <= 1'h1;
      penable <= 1'h0;
      pwrite  <= w;
      paddr   <= a;
      pwdata  <= d;
      @(posedge clk);
      penable <= 1'h1;
      do begin
         @(posedge clk);
         k++;
      end while (!pready && k < 16);
      r = prdata;
      e = pslverr;
      psel    <= 1'h0;
      penable <= 1'h0;
   endtask
   // falling edges until a channel pulse shows, at most lim
   task automatic measure(input logic ch, input int lim, output int k);
      k = 0;
      do begin
         @(negedge clk);
         k++;
      end while (!(ch ? wait_period_irq : trigger_period_irq) && k < lim);
   endtask
   initial begin
      reset_n = 1'h0;
      psel    = 1'h0;
      penable = 1'h0;
      pwrite  = 1'h0;
      paddr   = 8'h00;
      pwdata  = 32'h0;
      rows = '{
         '{1'h0, `TRIG_PERIOD_OFF, 32'h0, 32'h0, 1'h0},
         '{1'h1, `TRIG_PERIOD_OFF, 32'h1234, 32'h0, 1'h0},
         '{1'h1, `PERIPH_EN_OFF, 32'h1, 32'h0, 1'h0},
         '{1'h0, `TRIG_PERIOD_OFF, 32'h0, 32'h7CFF, 1'h0},
         '{1'h0, `WAIT_PERIOD_OFF, 32'h0, 32'h1F, 1'h0},
         '{1'h0, `TRIG_MODE_OFF, 32'h0, 32'h0, 1'h0},
         '{1'h0, `WAIT_MODE_OFF, 32'h0, 32'h0, 1'h0},
         '{1'h0, `PRESCALER_OFF, 32'h0, 32'h0, 1'h0},
         '{1'h0, 8'h40, 32'h0, 32'h0, 1'h1},
         '{1'h1, 8'h44, 32'h1, 32'h0, 1'h1},
         '{1'h1, `WAIT_PERIOD_OFF, 32'h1F, 32'h0, 1'h0}};
      repeat (2) @(posedge clk);
      reset_n <= 1'h1;
      for (int i = 0; i < 11; i++) begin
         apb(rows[i].w, rows[i].a, rows[i].d, rd, er);
         `CHK("pslverr", rows[i].err, er)
         if (!rows[i].w) `CHK("prdata", rows[i].ex, rd)
      end
      // short wait interval: first gap includes the start edge
      apb(1'h1, `START_OFF, 32'h2, rd, er);
      measure(1'h1, 40, n);
      `CHK("wait first gap", 33, n)
      measure(1'h1, 40, n);
      `CHK("wait gap", 32, n)
      apb(1'h0, `IRQ_STATUS_OFF, 32'h0, rd, er);
      `CHK("status", 32'h2, rd)
      `CHK("irq masked", 1'h0, irq)
      apb(1'h1, `IRQ_MASK_OFF, 32'h2, rd, er);
      @(negedge clk);
      `CHK("irq", 1'h1, irq)
      apb(1'h1, `STOP_OFF, 32'h2, rd, er);
      apb(1'h1, `IRQ_STATUS_OFF, 32'h2, rd, er);
      @(negedge clk);
      `CHK("irq cleared", 1'h0, irq)
      // a start with a hardware source selected must be ignored
      apb(1'h1, `WAIT_MODE_OFF, 32'h100, rd, er);
      apb(1'h1, `START_OFF, 32'h2, rd, er);
      measure(1'h1, 40, n);
      `CHK("hw start ignored", 40, n)
      apb(1'h1, `WAIT_MODE_OFF, 32'h0, rd, er);
      // both channels at the 1 ms setting, started together
      apb(1'h1, `WAIT_PERIOD_OFF, 32'h7CFF, rd, er);
      apb(1'h1, `START_OFF, 32'h3, rd, er);
      measure(1'h0, 40000, n);
      `CHK("trig first gap", 32001, n)
      `CHK("wait in step", 1'h1, wait_period_irq)
      measure(1'h0, 40000, n);
      `CHK("trig gap", 32000, n)
      @(negedge clk);
      `CHK("conversions", 16'h2, conv_count)
      apb(1'h0, `RUN_STATUS_OFF, 32'h0, rd, er);
      `CHK("running", 32'h3, rd)
      // switching the unit off stops both channels
      apb(1'h1, `PERIPH_EN_OFF, 32'h0, rd, er);
      apb(1'h0, `RUN_STATUS_OFF, 32'h0, rd, er);
      `CHK("run off", 32'h0, rd)
      measure(1'h0, 40, n);
      `CHK("no pulse off", 40, n)
      // mid-run reset: the enable and the pending interrupt must clear
      apb(1'h1, `PERIPH_EN_OFF, 32'h1, rd, er);
      `CHK("irq before reset", 1'h1, irq)
      @(posedge clk);
      reset_n <= 1'h0;
      repeat (2) @(posedge clk);
      reset_n <= 1'h1;
      `CHK("irq after reset", 1'h0, irq)
      apb(1'h0, `PERIPH_EN_OFF, 32'h0, rd, er);
      `CHK("enable after reset", 32'h0, rd)
      report_and_stop();
   end
endmodule
